// *** design/rifs_pkg.sv ***
// constants shared by the reader interrupt and fifo status block
// Behaviour
// - any edge of osc, pll or field-good status sets the analog-change bit
// - end of direct command execution sets the command-done bit
// - short reception, disabled command or protocol violation sets length/protocol sub-bit
// - preamble failure or fifo overflow in rx or tx sets preamble/overflow sub-bit
// - second status register zero after reset or chip disable, cleared by host read
// - interrupt pin high while any enabled bit is set in either status register
// - every error source raises both summary error and its own sub-bit
// - transmit-active status bit reads one while transmitting
// - receive-active status bit reads one while receiving
// - fifo overflow bit set when more than 24 bytes loaded
// - five-bit unread count, showing 1fh after an empty fifo is read
// - no-crc control bit makes reception run without crc handling
// - direct-fifo bit passes all bytes incl. crc, header irq becomes second-byte irq
// - repeat bit adds interrupts after fourth and sixth bytes in direct mode only; host may clear it
// - auto error-code preset loads 41-bit length when received header bit is one
// - status bits always set on events; enables only gate the pin
// - header irq flags high header bit, or two bytes in fifo in direct mode
// - short inventory commands preset 16 bits, handle request presets 32 bits
package rifs_pkg;
    // register offsets
    localparam logic [7:0] RIFS_ADDR_IRQ2     = 8'h38;
    localparam logic [7:0] RIFS_ADDR_FIFO_ST  = 8'h39;
    localparam logic [7:0] RIFS_ADDR_RXLEN_HI = 8'h3a;
    // second status register fields
    localparam int RIFS_IRQ2_ANA    = 7;
    localparam int RIFS_IRQ2_CMD    = 6;
    localparam int RIFS_IRQ2_CRC    = 2;
    localparam int RIFS_IRQ2_LEN    = 1;
    localparam int RIFS_IRQ2_PRE    = 0;
    localparam logic [7:0] RIFS_IRQ2_USED  = 8'hc7;
    localparam logic [7:0] RIFS_IRQ2_RESET = 8'h00;
    // fifo status fields
    localparam int RIFS_FST_TX   = 7;
    localparam int RIFS_FST_RX   = 6;
    localparam int RIFS_FST_OVFL = 5;
    localparam logic [4:0] RIFS_FIFO_EMPTY_READ = 5'h1f;
    localparam int RIFS_FIFO_DEPTH = 24;
    // receive length control fields
    localparam int RIFS_RXC_NOCRC  = 7;
    localparam int RIFS_RXC_DIRECT = 6;
    localparam int RIFS_RXC_REPEAT = 5;
    localparam int RIFS_RXC_AUTOEC = 4;
    localparam logic [7:0] RIFS_RXC_RESET = 8'h00;
    // preset lengths in bits
    localparam logic [11:0] RIFS_LEN_SHORT   = 12'h010;
    localparam logic [11:0] RIFS_LEN_HANDLE  = 12'h020;
    localparam logic [11:0] RIFS_LEN_ERRCODE = 12'h029;
    localparam logic [11:0] RIFS_LEN_RESET   = 12'h000;
    // direct command codes with length preset
    localparam logic [7:0] RIFS_CMD_SHORT_LO = 8'h98;
    localparam logic [7:0] RIFS_CMD_SHORT_HI = 8'h9c;
    localparam logic [7:0] RIFS_CMD_HANDLE   = 8'h9f;
    // received byte numbers that raise the byte interrupt
    localparam logic [3:0] RIFS_BYTE_SECOND = 4'h2;
    localparam logic [3:0] RIFS_BYTE_FOURTH = 4'h4;
    localparam logic [3:0] RIFS_BYTE_SIXTH  = 4'h6;

    typedef enum logic [0:0] {RIFS_RX_IDLE, RIFS_RX_BUSY} rifs_rx_state_t;
endpackage : rifs_pkg

// *** design/rifs_rx_monitor.sv ***
// receive-side monitor: expected length, header and byte interrupts, short error
`timescale 1ns/1ps
module rifs_rx_monitor
    import rifs_pkg::*;
#(
    parameter int LEN_W = 12
)(
    input  wire logic             clk,          // system clock
    input  wire logic             rst,          // async reset, high
    input  wire logic             en,           // chip enable, low clears
    input  wire logic [7:0]       ctrl,         // receive length control register
    input  wire logic             len_hi_wr,    // host write of length msb nibble
    input  wire logic [LEN_W-9:0] len_hi,       // written msb nibble
    input  wire logic             len_lo_wr,    // host write of length lsb byte
    input  wire logic [7:0]       len_lo,       // written lsb byte
    input  wire logic             cmd_start,    // direct command taken
    input  wire logic [7:0]       cmd_code,     // its code
    input  wire logic             rx_start,     // reception begins
    input  wire logic             rx_header_v,  // header bit valid
    input  wire logic             rx_header,    // header bit value
    input  wire logic             rx_byte_v,    // one byte received
    input  wire logic             rx_end,       // reception finished
    input  wire logic [LEN_W-1:0] rx_bits,      // bits received at end
    output logic [LEN_W-1:0]      exp_len,      // expected receive length
    output logic                  header_irq,   // header or byte interrupt pulse
    output logic                  short_err     // reception too short pulse
);
    rifs_rx_state_t   state_r;
    logic [3:0]       byte_cnt_r;
    logic [LEN_W-1:0] len_r;
    logic             hit;

    function automatic logic byte_hit(input logic [3:0] n, input logic [7:0] c);
        byte_hit = (n == RIFS_BYTE_SECOND)
                 || (c[RIFS_RXC_REPEAT] && (n == RIFS_BYTE_FOURTH || n == RIFS_BYTE_SIXTH));
    endfunction : byte_hit

    assign exp_len = len_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_r <= RIFS_RX_IDLE;
        else if (!en)
            state_r <= RIFS_RX_IDLE;
        else
            case (state_r)
                RIFS_RX_IDLE: if (rx_start) state_r <= RIFS_RX_BUSY;
                RIFS_RX_BUSY: if (rx_end)   state_r <= RIFS_RX_IDLE;
                default:      state_r <= RIFS_RX_IDLE;
            endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            byte_cnt_r <= 4'h0;
        else if (!en || rx_start)
            byte_cnt_r <= 4'h0;
        else if (rx_byte_v && state_r == RIFS_RX_BUSY && byte_cnt_r != 4'hf)
            byte_cnt_r <= byte_cnt_r + 4'h1;
    end

    // later write wins: error-code preset overrides the host's length
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            len_r <= RIFS_LEN_RESET;
        else if (!en)
            len_r <= RIFS_LEN_RESET;
        else if (rx_header_v && rx_header && ctrl[RIFS_RXC_AUTOEC])
            len_r <= RIFS_LEN_ERRCODE;
        else if (cmd_start && cmd_code == RIFS_CMD_HANDLE)
            len_r <= RIFS_LEN_HANDLE;
        else if (cmd_start && cmd_code >= RIFS_CMD_SHORT_LO && cmd_code <= RIFS_CMD_SHORT_HI)
            len_r <= RIFS_LEN_SHORT;
        else
        begin
            if (len_hi_wr) len_r[LEN_W-1:8] <= len_hi;
            if (len_lo_wr) len_r[7:0]       <= len_lo;
        end
    end

    // repeat bit is sampled live so the host can stop it mid-reception
    assign hit = rx_byte_v && state_r == RIFS_RX_BUSY
              && byte_hit(byte_cnt_r + 4'h1, ctrl);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            header_irq <= 1'b0;
        else if (!en)
            header_irq <= 1'b0;
        else if (ctrl[RIFS_RXC_DIRECT])
            header_irq <= hit;
        else
            header_irq <= rx_header_v && rx_header;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            short_err <= 1'b0;
        else
            short_err <= en && rx_end && state_r == RIFS_RX_BUSY && rx_bits < len_r;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    preset_handle_a: assert property (en && cmd_start && cmd_code == RIFS_CMD_HANDLE
        && !(rx_header_v && rx_header && ctrl[RIFS_RXC_AUTOEC]) |=> len_r == RIFS_LEN_HANDLE)
        else $error("handle request did not preset 32 bits");
    errcode_len_a: assert property (en && rx_header_v && rx_header && ctrl[RIFS_RXC_AUTOEC]
        |=> len_r == RIFS_LEN_ERRCODE)
        else $error("error code length not preset");
    short_rx_a: assert property (en && rx_end && state_r == RIFS_RX_BUSY && rx_bits < len_r
        |=> short_err)
        else $error("short reception not flagged");
endmodule : rifs_rx_monitor

// *** design/rifs_top.sv ***
// interrupt status two, fifo status and receive length control of the reader
`timescale 1ns/1ps
module rifs_top
    import rifs_pkg::*;
#(
    parameter int FIFO_DEPTH = RIFS_FIFO_DEPTH,
    parameter int LEN_W      = 12
)(
    input  wire logic             CLK,            // system clock, 10 MHz
    input  wire logic             RST,            // async reset, high
    input  wire logic             EN,             // chip enable, low clears
    input  wire logic [7:0]       REG_ADDR,       // host register address
    input  wire logic             REG_WR,         // write strobe, one cycle
    input  wire logic [7:0]       REG_WDATA,      // write data
    input  wire logic             REG_RD,         // read phase end strobe
    input  wire logic [7:0]       IRQ2_ENABLE,    // enable register two contents
    input  wire logic             IRQ1_PENDING,   // enabled bit set in register one
    input  wire logic             OSC_OK,         // oscillator ok
    input  wire logic             PLL_OK,         // pll locked
    input  wire logic             FIELD_GOOD,     // rf field ok
    input  wire logic             CMD_START,      // direct command taken, pulse
    input  wire logic [7:0]       CMD_CODE,       // direct command code
    input  wire logic             CMD_DONE,       // direct command finished, pulse
    input  wire logic             TX_BUSY,        // transmission in progress
    input  wire logic             RX_BUSY,        // reception in progress
    input  wire logic             RX_START,       // reception begins, pulse
    input  wire logic             RX_HEADER_V,    // header bit valid, pulse
    input  wire logic             RX_HEADER,      // header bit value
    input  wire logic             RX_BYTE_V,      // byte received, pulse
    input  wire logic             RX_END,         // reception finished, pulse
    input  wire logic [LEN_W-1:0] RX_BITS,        // bits received at end
    input  wire logic             CRC_ERR,        // crc error, pulse
    input  wire logic             PROTO_ERR,      // disabled cmd or violation, pulse
    input  wire logic             PREAMBLE_ERR,   // preamble detect failure, pulse
    input  wire logic             FIFO_PUSH,      // byte loaded into fifo
    input  wire logic             FIFO_POP,       // byte read from fifo
    input  wire logic             FIFO_CLEAR,     // fifo emptied
    input  wire logic             RX_LEN_LO_WR,   // lsb length register written
    input  wire logic [7:0]       RX_LEN_LO,      // lsb length value
    output logic [7:0]            REG_RDATA,      // read data, valid after REG_RD
    output logic                  IRQ,            // interrupt pin
    output logic                  IRQ1_ERR_SET,   // summary error event to register one
    output logic                  IRQ1_HDR_SET,   // header or byte event to register one
    output logic [LEN_W-1:0]      RX_EXP_LEN,     // expected receive length
    output logic                  RX_CRC_EN,      // crc handling enabled
    output logic                  RX_ALL_TO_FIFO  // all bytes incl. crc go to fifo
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]       irq2_r;
    logic [7:0]       irq2_nxt;
    logic [7:0]       rxc_r;
    logic [4:0]       fcnt_r;
    logic             ovfl_r;
    logic             empty_rd_r;
    logic [2:0]       ana_r;
    logic             ana_vld_r;
    logic             ana_chg;
    logic             fifo_ovf_ev;
    logic             hdr_irq;
    logic             short_err;
    logic [LEN_W-1:0] exp_len;
    logic             rd_irq2;
    logic             wr_rxc;
    logic [7:0]       fstat;

    function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] off);
        hit_addr = (a == off);
    endfunction : hit_addr

    assign rd_irq2 = REG_RD && hit_addr(REG_ADDR, RIFS_ADDR_IRQ2);
    assign wr_rxc  = REG_WR && hit_addr(REG_ADDR, RIFS_ADDR_RXLEN_HI);

    ////////////////////////////////////////////////////////////////////////
    // analog status edge detect
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ana_r <= 3'h0;
        else
            ana_r <= {OSC_OK, PLL_OK, FIELD_GOOD};
    end

    // first sample after reset only primes the detector, so a pin already high is no edge
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ana_vld_r <= 1'b0;
        else
            ana_vld_r <= 1'b1;
    end

    // inputs are synchronous; both edges count
    assign ana_chg = ana_vld_r && (ana_r != {OSC_OK, PLL_OK, FIELD_GOOD});

    ////////////////////////////////////////////////////////////////////////
    // fifo occupancy
    assign fifo_ovf_ev = FIFO_PUSH && !FIFO_POP && fcnt_r >= 5'(FIFO_DEPTH);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            fcnt_r <= 5'h00;
        else if (!EN || FIFO_CLEAR)
            fcnt_r <= 5'h00;
        else if (FIFO_PUSH && !FIFO_POP && fcnt_r < 5'(FIFO_DEPTH))
            fcnt_r <= fcnt_r + 5'h01;
        else if (FIFO_POP && !FIFO_PUSH && fcnt_r != 5'h00)
            fcnt_r <= fcnt_r - 5'h01;
    end

    // sticky until fifo is cleared so software can see it after the frame
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ovfl_r <= 1'b0;
        else if (!EN)
            ovfl_r <= 1'b0;
        else if (fifo_ovf_ev)
            ovfl_r <= 1'b1;
        else if (FIFO_CLEAR)
            ovfl_r <= 1'b0;
    end

    // an empty read shows 1fh until the next byte arrives
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            empty_rd_r <= 1'b0;
        else if (!EN || FIFO_CLEAR || FIFO_PUSH)
            empty_rd_r <= 1'b0;
        else if (FIFO_POP && fcnt_r == 5'h00)
            empty_rd_r <= 1'b1;
    end

    always_comb
    begin
        fstat              = 8'h00;
        fstat[RIFS_FST_TX] = TX_BUSY;
        fstat[RIFS_FST_RX] = RX_BUSY;
        fstat[RIFS_FST_OVFL] = ovfl_r;
        fstat[4:0]         = empty_rd_r ? RIFS_FIFO_EMPTY_READ : fcnt_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // receive length control register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rxc_r <= RIFS_RXC_RESET;
        else if (!EN)
            rxc_r <= RIFS_RXC_RESET;
        else if (wr_rxc)
            rxc_r <= {REG_WDATA[7:4], 4'h0};
    end

    rifs_rx_monitor #(
        .LEN_W       (LEN_W)
    ) u_rxmon (
        .clk         (CLK),
        .rst         (RST),
        .en          (EN),
        .ctrl        (rxc_r),
        .len_hi_wr   (wr_rxc),
        .len_hi      (REG_WDATA[LEN_W-9:0]),
        .len_lo_wr   (RX_LEN_LO_WR),
        .len_lo      (RX_LEN_LO),
        .cmd_start   (CMD_START),
        .cmd_code    (CMD_CODE),
        .rx_start    (RX_START),
        .rx_header_v (RX_HEADER_V),
        .rx_header   (RX_HEADER),
        .rx_byte_v   (RX_BYTE_V),
        .rx_end      (RX_END),
        .rx_bits     (RX_BITS),
        .exp_len     (exp_len),
        .header_irq  (hdr_irq),
        .short_err   (short_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // second interrupt status register
    always_comb
    begin
        irq2_nxt = irq2_r;
        if (rd_irq2)
            irq2_nxt = RIFS_IRQ2_RESET;
        // set after clear so a same-cycle event survives the read
        if (ana_chg)                  irq2_nxt[RIFS_IRQ2_ANA] = 1'b1;
        if (CMD_DONE)                 irq2_nxt[RIFS_IRQ2_CMD] = 1'b1;
        if (CRC_ERR)                  irq2_nxt[RIFS_IRQ2_CRC] = 1'b1;
        if (short_err || PROTO_ERR)   irq2_nxt[RIFS_IRQ2_LEN] = 1'b1;
        if (PREAMBLE_ERR || fifo_ovf_ev) irq2_nxt[RIFS_IRQ2_PRE] = 1'b1;
        irq2_nxt = irq2_nxt & RIFS_IRQ2_USED;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            irq2_r <= RIFS_IRQ2_RESET;
        else if (!EN)
            irq2_r <= RIFS_IRQ2_RESET;
        else
            irq2_r <= irq2_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            IRQ <= 1'b0;
        else
            IRQ <= EN && (IRQ1_PENDING || |(irq2_nxt & IRQ2_ENABLE & RIFS_IRQ2_USED));
    end

    // each error feeds the summary bit independently of its sub-bit
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            IRQ1_ERR_SET <= 1'b0;
        else
            IRQ1_ERR_SET <= EN && (CRC_ERR || short_err || PROTO_ERR
                                   || PREAMBLE_ERR || fifo_ovf_ev);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            IRQ1_HDR_SET <= 1'b0;
        else
            IRQ1_HDR_SET <= EN && hdr_irq;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RX_EXP_LEN     <= RIFS_LEN_RESET;
            RX_CRC_EN      <= 1'b1;
            RX_ALL_TO_FIFO <= 1'b0;
        end
        else
        begin
            RX_EXP_LEN     <= exp_len;
            RX_CRC_EN      <= !rxc_r[RIFS_RXC_NOCRC];
            RX_ALL_TO_FIFO <= rxc_r[RIFS_RXC_DIRECT];
        end
    end

    // read data captured before the read-clear takes effect
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            case (REG_ADDR)
                RIFS_ADDR_IRQ2:     REG_RDATA <= irq2_r & RIFS_IRQ2_USED;
                RIFS_ADDR_FIFO_ST:  REG_RDATA <= fstat;
                RIFS_ADDR_RXLEN_HI: REG_RDATA <= {rxc_r[7:4], exp_len[LEN_W-1:8]};
                default:            REG_RDATA <= 8'h00;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_read_irq2;
        EN && rd_irq2 && !ana_chg && !CMD_DONE && !CRC_ERR;
    endsequence

    sequence s_quiet;
        !short_err && !PROTO_ERR && !PREAMBLE_ERR && !fifo_ovf_ev;
    endsequence

    ana_edge_a: assert property (EN && ana_chg |=> irq2_r[RIFS_IRQ2_ANA])
        else $error("analog change not latched");
    cmd_done_a: assert property (EN && CMD_DONE |=> irq2_r[RIFS_IRQ2_CMD])
        else $error("command done not latched");
    pre_ovf_a: assert property (EN && (PREAMBLE_ERR || fifo_ovf_ev) |=> irq2_r[RIFS_IRQ2_PRE])
        else $error("preamble or overflow not latched");
    read_clear_a: assert property (s_read_irq2 ##0 s_quiet |=> irq2_r == 8'h00)
        else $error("status two not cleared by read");
    disable_clear_a: assert property (!EN |=> irq2_r == 8'h00 && !IRQ)
        else $error("chip disable did not clear status");
    irq_pin_a: assert property (EN && |(irq2_r & IRQ2_ENABLE) && !rd_irq2 |=> IRQ)
        else $error("interrupt pin low with enabled bit set");
    err_both_a: assert property (EN && CRC_ERR |=> IRQ1_ERR_SET && irq2_r[RIFS_IRQ2_CRC])
        else $error("error not routed to both registers");
    reserved_zero_a: assert property ((irq2_r & ~RIFS_IRQ2_USED) == 8'h00)
        else $error("reserved status bit set");
    ovfl_sticky_a: assert property (EN && fifo_ovf_ev
        |=> ovfl_r ##1 (ovfl_r || $past(FIFO_CLEAR) || !$past(EN)))
        else $error("overflow bit not held");
    hdr_event_a: assert property (EN && hdr_irq |=> IRQ1_HDR_SET)
        else $error("header event not passed on");
    empty_code_a: assert property (EN && FIFO_POP && fcnt_r == 5'h00 && !FIFO_PUSH && !FIFO_CLEAR
        |=> fstat[4:0] == RIFS_FIFO_EMPTY_READ)
        else $error("empty read code missing");
    crc_mode_a: assert property (rxc_r[RIFS_RXC_NOCRC] |=> !RX_CRC_EN)
        else $error("crc not disabled");
endmodule : rifs_top

// *** tb/rifs_host.sv ***
// host model: register reads and writes over the status port
`timescale 1ns/1ps
module rifs_host (
    input  wire logic       CLK,   // system clock
    input  wire logic [7:0] RDATA, // read data
    output logic [7:0]      ADDR,  // address
    output logic            WR,    // write strobe
    output logic [7:0]      WDATA, // write data
    output logic            RD     // read strobe
);
    initial {ADDR, WR, WDATA, RD} = 18'h0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge CLK) {ADDR, WDATA, WR} = {a, v, 1'b1};
        @(negedge CLK) WR = 1'b0;
        // released lines must not keep the last value
        {ADDR, WDATA} = ~{ADDR, WDATA};
    endtask : wr
    // data stands from the cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge CLK) {ADDR, RD} = {a, 1'b1};
        @(negedge CLK) RD = 1'b0;
        v = RDATA;
        ADDR = ~ADDR;
    endtask : rd
endmodule : rifs_host

// *** tb/testbench.sv ***
// self-checking testbench of the reader status block
`timescale 1ns/1ps
module testbench;
    import rifs_pkg::*;
    logic CLK = 0, RST = 1, EN = 1, OSC_OK = 0, PLL_OK = 0, FIELD_GOOD = 0, CMD_START = 0;
    logic CMD_DONE = 0, TX_BUSY = 0, RX_BUSY = 0, RX_START = 0, RX_HEADER_V = 0, RX_HEADER = 0;
    logic RX_END = 0, CRC_ERR = 0, PROTO_ERR = 0, PREAMBLE_ERR = 0, FIFO_PUSH = 0, FIFO_POP = 0;
    logic FIFO_CLEAR = 0, REG_WR, REG_RD, IRQ, IRQ1_ERR_SET, IRQ1_HDR_SET, RX_CRC_EN, RX_ALL_TO_FIFO;
    logic IRQ1_PENDING = 0, RX_BYTE_V = 0;
    logic [7:0] IRQ2_ENABLE = 8'h00, CMD_CODE = 8'h00, REG_ADDR, REG_WDATA, REG_RDATA, d;
    logic [11:0] RX_BITS = 12'h000, RX_EXP_LEN;
    int mismatches = 0, total_checks = 0, cyc = 0;
    rifs_top rifs_top_inst (.CLK, .RST, .EN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .IRQ2_ENABLE,
        .IRQ1_PENDING, .OSC_OK, .PLL_OK, .FIELD_GOOD, .CMD_START, .CMD_CODE, .CMD_DONE, .TX_BUSY,
        .RX_BUSY, .RX_START, .RX_HEADER_V, .RX_HEADER, .RX_BYTE_V, .RX_END, .RX_BITS, .CRC_ERR,
        .PROTO_ERR, .PREAMBLE_ERR, .FIFO_PUSH, .FIFO_POP, .FIFO_CLEAR, .RX_LEN_LO_WR(1'b0),
        .RX_LEN_LO(8'h00), .REG_RDATA, .IRQ, .IRQ1_ERR_SET, .IRQ1_HDR_SET, .RX_EXP_LEN, .RX_CRC_EN,
        .RX_ALL_TO_FIFO);
    rifs_host rifs_host_inst (.CLK, .RDATA(REG_RDATA), .ADDR(REG_ADDR), .WR(REG_WR), .WDATA(REG_WDATA),
        .RD(REG_RD));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rifs_host_inst.rd(a, d);
        chk(d & m, e);
    endtask : rd_chk
    task automatic pulse(ref logic s);
        @(negedge CLK) s = 1'b1;
        @(negedge CLK) s = 1'b0;
    endtask : pulse
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_analog();
        chk(RX_CRC_EN, 1'b1);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, RIFS_IRQ2_RESET);
        IRQ2_ENABLE = 8'h80;
        @(negedge CLK) OSC_OK = 1'b1;
        @(negedge CLK) chk(IRQ, 1'b1);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h80);
        chk(IRQ, 1'b0);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h00);
        @(negedge CLK) OSC_OK = 1'b0;
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h80);
        @(negedge CLK) PLL_OK = 1'b1;
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h80);
        @(negedge CLK) FIELD_GOOD = 1'b1;
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h80);
        IRQ2_ENABLE = 8'h40;
        pulse(CMD_DONE);
        chk(IRQ, 1'b1);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h40);
        $display("test analog and command done");
    endtask : t_analog
    // only reserved enables set: pin must stay low
    task automatic t_err(ref logic s, input logic [7:0] e);
        IRQ2_ENABLE = 8'h38;
        pulse(s);
        chk(IRQ1_ERR_SET, 1'b1);
        chk(IRQ, 1'b0);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, e);
        IRQ1_PENDING = 1'b1;
        @(negedge CLK) chk(IRQ, 1'b1);
        IRQ1_PENDING = 1'b0;
        pulse(s);
        @(negedge CLK) EN = 1'b0;
        @(negedge CLK) EN = 1'b1;
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h00);
        $display("test error %h", e);
    endtask : t_err
    task automatic t_fifo();
        {TX_BUSY, RX_BUSY} = 2'b11;
        @(negedge CLK) FIFO_PUSH = 1'b1;
        repeat (24) @(negedge CLK);
        FIFO_PUSH = 1'b0;
        rd_chk(RIFS_ADDR_FIFO_ST, 8'hff, 8'hd8);
        pulse(FIFO_PUSH);
        rd_chk(RIFS_ADDR_FIFO_ST, 8'he0, 8'he0);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h01);
        {TX_BUSY, RX_BUSY} = 2'b00;
        pulse(FIFO_CLEAR);
        pulse(FIFO_POP);
        rd_chk(RIFS_ADDR_FIFO_ST, 8'hff, 8'h1f);
        $display("test fifo status");
    endtask : t_fifo
    task automatic t_len();
        rifs_host_inst.wr(RIFS_ADDR_RXLEN_HI, 8'h83);
        rd_chk(RIFS_ADDR_RXLEN_HI, 8'hff, 8'h83);
        chk(RX_CRC_EN, 1'b0);
        chk(RX_EXP_LEN, 12'h300);
        rifs_host_inst.wr(RIFS_ADDR_RXLEN_HI, 8'h50);
        @(negedge CLK) chk(RX_ALL_TO_FIFO, 1'b1);
        CMD_CODE = 8'h9f;
        pulse(CMD_START);
        @(negedge CLK) chk(RX_EXP_LEN, RIFS_LEN_HANDLE);
        CMD_CODE = 8'h98;
        pulse(CMD_START);
        @(negedge CLK) chk(RX_EXP_LEN, RIFS_LEN_SHORT);
        pulse(RX_START);
        // direct mode: second byte raises the header event, repeat adds the fourth
        repeat (2) pulse(RX_BYTE_V);
        @(negedge CLK) chk(IRQ1_HDR_SET, 1'b1);
        rifs_host_inst.wr(RIFS_ADDR_RXLEN_HI, 8'h70);
        repeat (2) pulse(RX_BYTE_V);
        @(negedge CLK) chk(IRQ1_HDR_SET, 1'b1);
        rifs_host_inst.wr(RIFS_ADDR_RXLEN_HI, 8'h50);
        repeat (2) pulse(RX_BYTE_V);
        @(negedge CLK) chk(IRQ1_HDR_SET, 1'b0);
        RX_BITS = 12'h008;
        pulse(RX_END);
        repeat (2) @(negedge CLK);
        rd_chk(RIFS_ADDR_IRQ2, 8'hff, 8'h02);
        rifs_host_inst.wr(RIFS_ADDR_RXLEN_HI, 8'h10);
        RX_HEADER = 1'b1;
        pulse(RX_HEADER_V);
        @(negedge CLK) chk(IRQ1_HDR_SET, 1'b1);
        chk(RX_EXP_LEN, RIFS_LEN_ERRCODE);
        $display("test receive length");
    endtask : t_len
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #50 CLK = ~CLK;
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            mismatches++;
            close_out();
        end
    end
    initial
    begin
        repeat (6) @(posedge CLK);
        @(negedge CLK) RST = 1'b0;
        t_analog();
        t_err(CRC_ERR, 8'h04);
        t_err(PROTO_ERR, 8'h02);
        t_err(PREAMBLE_ERR, 8'h01);
        t_fifo();
        t_len();
        close_out();
    end
endmodule : testbench
